// ### rtl/lcfg_map.svh
// command identifiers, field positions, reset values and link timing of the config link
`ifndef LCFG_MAP_SVH
`define LCFG_MAP_SVH

// write command identifiers
`define LCFG_ID_WR_CFG0        16'hAA00
`define LCFG_ID_WR_OPEN_LOC    16'hAA0E
`define LCFG_ID_WR_SHORT_LOC   16'hAA0F
`define LCFG_ID_WR_CHIP_INDEX  16'hAA10
`define LCFG_ID_GS_WRITE       16'hAA30
`define LCFG_ID_SOFT_RESET     16'hAA80
`define LCFG_ID_POWER_SAVE     16'hAA90
`define LCFG_ID_STANDBY_EXIT   16'hAAB0
`define LCFG_ID_STANDBY_ENTRY  16'hAAB1
`define LCFG_ID_VSYNC          16'hAAF0

// read command identifiers
`define LCFG_ID_RD_CFG0        16'hAA60
`define LCFG_ID_RD_OPEN_LOC    16'hAA6E
`define LCFG_ID_RD_SHORT_LOC   16'hAA6F
`define LCFG_ID_RD_CHIP_INDEX  16'hAA70
`define LCFG_ID_RD_OPEN_LINES  16'hAAA1
`define LCFG_ID_RD_SHORT_LINES 16'hAAA3
`define LCFG_ID_RD_OPEN_CHANS  16'hAAA4
`define LCFG_ID_RD_SHORT_CHANS 16'hAAA5

// first common configuration register: reset value and writable bits; locate and chip index reset values
`define LCFG_CFG0_RESET        48'h2000_E000_0107
`define LCFG_CFG0_WMASK        48'h9FF1_F1DF_F11F
`define LCFG_LOC_RESET         5'h00
`define LCFG_CHIP_INDEX_RESET  5'h00

// field positions inside the first common configuration register, plus the locate and chip index field
`define LCFG_F_DEVICE_COUNT    4:0
`define LCFG_F_PREDISCHARGE    8
`define LCFG_F_POWER_SAVE      12
`define LCFG_F_PS_PLUS_LEVEL   14:13
`define LCFG_F_OPEN_REMOVAL    15
`define LCFG_F_SCAN_LINES      20:16
`define LCFG_F_SUBPERIODS      24:22
`define LCFG_F_MULT_RANGE      28
`define LCFG_F_MULT_FACTOR     32:29
`define LCFG_F_RED_DELAY       38:36
`define LCFG_F_GREEN_DELAY     41:39
`define LCFG_F_BLUE_DELAY      44:42
`define LCFG_F_SHORT_REMOVAL   47
`define LCFG_F_LOC             4:0

// frame layout: 16 identifier bits then 48 data bits, most significant first
`define LCFG_BIT_LAST_ID       7'h0F
`define LCFG_BIT_LAST          7'h3F
`define LCFG_BIT_DONE          7'h40
`define LCFG_BIT_ZERO          7'h00
`define LCFG_BIT_ONE           7'h01

// serial clock made by the host: half period in system clocks (6 x 4 ns)
`define LCFG_SCLK_HALF_LAST    3'h5
`define LCFG_DIV_ZERO          3'h0
`define LCFG_DIV_ONE           3'h1

`endif

// ### rtl/lcfg_pkg.sv
// shared types and command decoding for the config link
`include "lcfg_map.svh"
package lcfg_pkg;
	typedef logic [15:0] lcfg_cmd_id_t;
	typedef logic [47:0] lcfg_word_t;
	typedef logic [63:0] lcfg_frame_t;
	typedef logic [6:0]  lcfg_bit_cnt_t;

	typedef enum logic [1:0] {
		LCFG_HOST_IDLE,
		LCFG_HOST_ARMED,
		LCFG_HOST_SHIFT
	} lcfg_host_state_t;

	// true for every identifier that asks the device to return a word
	function automatic logic lcfg_is_read_id(input lcfg_cmd_id_t id);
		case (id)
			`LCFG_ID_RD_CFG0, `LCFG_ID_RD_OPEN_LOC, `LCFG_ID_RD_SHORT_LOC,
			`LCFG_ID_RD_CHIP_INDEX, `LCFG_ID_RD_OPEN_LINES, `LCFG_ID_RD_SHORT_LINES,
			`LCFG_ID_RD_OPEN_CHANS, `LCFG_ID_RD_SHORT_CHANS: lcfg_is_read_id = 1'b1;
			default: lcfg_is_read_id = 1'b0;
		endcase
	endfunction : lcfg_is_read_id
endpackage : lcfg_pkg

// ### rtl/lcfg_link_if.sv
// three-wire serial link plus frame marker between host and device
interface lcfg_link_if;
	logic sclk;   // serial clock, made by the host
	logic sin;    // host to device data
	logic frame;  // high while a 64-bit frame is shifted
	logic sout;   // device to host data

	modport device (input sclk, input sin, input frame, output sout);
	modport host   (output sclk, output sin, output frame, input sout);
endinterface : lcfg_link_if

// ### rtl/lcfg_device.sv
// device end: serial command decoder and configuration register bank
//
// Overview of operation
// - open-line locate: write AA0E, read AA6E
// - short-line locate: write AA0F, read AA6F
// - line warnings read at AAA1, AAA3
// - channel warnings read at AAA4, AAA5 only
// - AA90 triggers matrix power saving, no readback
// - AAB0 leaves standby
// - AAB1 enters standby
// - AA80 resets registers, grayscale memory untouched
// - AA30 writes grayscale pixel data
// - bits 4-0 device count minus one
// - bit 8 pre-discharge enable, resets one
// - bit 12 power saving enable
// - bits 14-13 extra power saving level
// - bit 15 open-LED removal enable
// - bits 20-16 scan lines minus one
// - bits 24-22 sub-period count selector
// - bit 28 multiplier frequency range
// - bits 32-29 multiplier factor minus one
// - red green blue group delays, forward PWM
// - bit 47 short caterpillar removal enable
// - link data most significant bit first
`include "lcfg_map.svh"
module lcfg_device (
	input  wire logic               clk,                          // system clock
	input  wire logic               rst,                          // async reset, high
	lcfg_link_if.device             link,                         // serial link
	input  wire logic [31:0]        open_line_warnings,           // open fault per line
	input  wire logic [31:0]        short_line_warnings,          // short fault per line
	input  wire logic [47:0]        open_channel_warnings,        // open fault per channel
	input  wire logic [47:0]        short_channel_warnings,       // short fault per channel
	output lcfg_pkg::lcfg_word_t    common_config_zero,           // whole config word
	output logic [4:0]              device_count,                 // devices minus one
	output logic                    predischarge_enable,          // pre-discharge on
	output logic                    power_save_enable,            // power saving on
	output logic [1:0]              power_save_plus_level,        // extra saving level
	output logic                    open_led_removal_enable,      // open removal on
	output logic [4:0]              scan_line_count,              // scan lines minus one
	output logic [2:0]              subperiod_count,              // sub-periods/16 minus one
	output logic                    multiplier_range_select,      // 1 = low range
	output logic [3:0]              multiplier_factor,            // multiplier minus one
	output logic [2:0]              red_group_delay,              // red delay in clocks
	output logic [2:0]              green_group_delay,            // green delay in clocks
	output logic [2:0]              blue_group_delay,             // blue delay in clocks
	output logic                    short_caterpillar_removal_enable, // short removal on
	output logic [4:0]              open_line_locate,             // line under open test
	output logic [4:0]              short_line_locate,            // line under short test
	output logic [4:0]              chip_index,                   // chip index
	output logic                    standby,                      // standby level
	output logic                    power_save_pulse,             // one-cycle action
	output logic                    vsync_pulse,                  // one-cycle frame sync
	output logic                    soft_reset_pulse,             // one-cycle soft reset
	output logic                    gs_write_pulse,               // one-cycle pixel write
	output lcfg_pkg::lcfg_word_t    gs_write_data                 // pixel data word
);
	logic [2:0]                 sclk_sync;
	logic [1:0]                 sin_sync;
	logic [1:0]                 frame_sync;
	logic                       bit_rise;
	logic                       in_frame;
	lcfg_pkg::lcfg_bit_cnt_t    bit_cnt;
	lcfg_pkg::lcfg_frame_t      in_shift;
	lcfg_pkg::lcfg_frame_t      next_word;
	lcfg_pkg::lcfg_word_t       out_shift;
	lcfg_pkg::lcfg_cmd_id_t     frame_id;
	lcfg_pkg::lcfg_word_t       frame_data;
	logic                       exec;
	logic                       id_done;

	// word returned for a read identifier; unknown ids return zero
	function automatic lcfg_pkg::lcfg_word_t read_value(input lcfg_pkg::lcfg_cmd_id_t id);
		case (id)
			`LCFG_ID_RD_CFG0:        read_value = common_config_zero;
			`LCFG_ID_RD_OPEN_LOC:    read_value = {43'h000_0000_0000, open_line_locate};
			`LCFG_ID_RD_SHORT_LOC:   read_value = {43'h000_0000_0000, short_line_locate};
			`LCFG_ID_RD_CHIP_INDEX:  read_value = {43'h000_0000_0000, chip_index};
			`LCFG_ID_RD_OPEN_LINES:  read_value = {16'h0000, open_line_warnings};
			`LCFG_ID_RD_SHORT_LINES: read_value = {16'h0000, short_line_warnings};
			`LCFG_ID_RD_OPEN_CHANS:  read_value = open_channel_warnings;
			`LCFG_ID_RD_SHORT_CHANS: read_value = short_channel_warnings;
			default:                 read_value = 48'h0000_0000_0000;
		endcase
	endfunction : read_value

	// link pins cross into clk; only the second stage and later are looked at
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_sync  <= 3'h0;
			sin_sync   <= 2'h0;
			frame_sync <= 2'h0;
		end else begin
			sclk_sync  <= {sclk_sync[1:0], link.sclk};
			sin_sync   <= {sin_sync[0], link.sin};
			frame_sync <= {frame_sync[0], link.frame};
		end
	end

	// sin and frame share the sclk delay, so they line up with the edge
	assign bit_rise  = sclk_sync[1] & ~sclk_sync[2];
	assign in_frame  = frame_sync[1];
	assign next_word = {in_shift[62:0], sin_sync[1]};
	assign frame_id  = next_word[63:48];
	assign frame_data = next_word[47:0];
	assign exec      = bit_rise & in_frame & (bit_cnt == `LCFG_BIT_LAST);
	assign id_done   = bit_rise & in_frame & (bit_cnt == `LCFG_BIT_LAST_ID);

	// bit counter; bits past 64 in one frame are dropped, frame low restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= `LCFG_BIT_ZERO;
		end else if (bit_rise) begin
			if (!in_frame) begin
				bit_cnt <= `LCFG_BIT_ZERO;
			end else if (bit_cnt != `LCFG_BIT_DONE) begin
				bit_cnt <= bit_cnt + `LCFG_BIT_ONE;
			end
		end
	end

	// receive shifter, first bit lands at the top
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_shift <= 64'h0000_0000_0000_0000;
		end else if (bit_rise && in_frame && bit_cnt != `LCFG_BIT_DONE) begin
			in_shift <= next_word;
		end
	end

	// readback: loaded once the 16th id bit is in, then one bit per rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_shift <= 48'h0000_0000_0000;
		end else if (bit_rise) begin
			if (!in_frame) begin
				out_shift <= 48'h0000_0000_0000;
			end else if (id_done && lcfg_pkg::lcfg_is_read_id(next_word[15:0])) begin
				out_shift <= read_value(next_word[15:0]);
			end else begin
				out_shift <= {out_shift[46:0], 1'b0};
			end
		end
	end

	assign link.sout = out_shift[47];

	// first config word; reserved bits always hold their reset value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			common_config_zero <= `LCFG_CFG0_RESET;
		end else if (exec && frame_id == `LCFG_ID_SOFT_RESET) begin
			common_config_zero <= `LCFG_CFG0_RESET;
		end else if (exec && frame_id == `LCFG_ID_WR_CFG0) begin
			common_config_zero <= (`LCFG_CFG0_RESET & ~`LCFG_CFG0_WMASK)
				| (frame_data & `LCFG_CFG0_WMASK);
		end
	end

	// locate registers pick the scan line for open and short tests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			open_line_locate  <= `LCFG_LOC_RESET;
			short_line_locate <= `LCFG_LOC_RESET;
		end else if (exec && frame_id == `LCFG_ID_SOFT_RESET) begin
			open_line_locate  <= `LCFG_LOC_RESET;
			short_line_locate <= `LCFG_LOC_RESET;
		end else if (exec && frame_id == `LCFG_ID_WR_OPEN_LOC) begin
			open_line_locate  <= frame_data[`LCFG_F_LOC];
		end else if (exec && frame_id == `LCFG_ID_WR_SHORT_LOC) begin
			short_line_locate <= frame_data[`LCFG_F_LOC];
		end
	end

	// chip index register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chip_index <= `LCFG_CHIP_INDEX_RESET;
		end else if (exec && frame_id == `LCFG_ID_SOFT_RESET) begin
			chip_index <= `LCFG_CHIP_INDEX_RESET;
		end else if (exec && frame_id == `LCFG_ID_WR_CHIP_INDEX) begin
			chip_index <= frame_data[`LCFG_F_LOC];
		end
	end

	// standby level; soft reset also wakes the device
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			standby <= 1'b0;
		end else if (exec && frame_id == `LCFG_ID_STANDBY_ENTRY) begin
			standby <= 1'b1;
		end else if (exec && (frame_id == `LCFG_ID_STANDBY_EXIT
				|| frame_id == `LCFG_ID_SOFT_RESET)) begin
			standby <= 1'b0;
		end
	end

	// action pulses, one clock each; any unlisted id falls through untouched
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_save_pulse <= 1'b0;
			vsync_pulse      <= 1'b0;
			soft_reset_pulse <= 1'b0;
			gs_write_pulse   <= 1'b0;
		end else begin
			power_save_pulse <= exec && frame_id == `LCFG_ID_POWER_SAVE;
			vsync_pulse      <= exec && frame_id == `LCFG_ID_VSYNC;
			soft_reset_pulse <= exec && frame_id == `LCFG_ID_SOFT_RESET;
			gs_write_pulse   <= exec && frame_id == `LCFG_ID_GS_WRITE;
		end
	end

	// pixel word held until the next grayscale write; memory itself lives outside
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gs_write_data <= 48'h0000_0000_0000;
		end else if (exec && frame_id == `LCFG_ID_GS_WRITE) begin
			gs_write_data <= frame_data;
		end
	end

	// field views of the config word, each straight off its flip-flops
	assign device_count             = common_config_zero[`LCFG_F_DEVICE_COUNT];
	assign predischarge_enable      = common_config_zero[`LCFG_F_PREDISCHARGE];
	assign power_save_enable        = common_config_zero[`LCFG_F_POWER_SAVE];
	assign power_save_plus_level    = common_config_zero[`LCFG_F_PS_PLUS_LEVEL];
	assign open_led_removal_enable  = common_config_zero[`LCFG_F_OPEN_REMOVAL];
	assign scan_line_count          = common_config_zero[`LCFG_F_SCAN_LINES];
	assign subperiod_count          = common_config_zero[`LCFG_F_SUBPERIODS];
	assign multiplier_range_select  = common_config_zero[`LCFG_F_MULT_RANGE];
	assign multiplier_factor        = common_config_zero[`LCFG_F_MULT_FACTOR];
	// delays only matter to forward PWM; the PWM engine must ignore them otherwise
	assign red_group_delay          = common_config_zero[`LCFG_F_RED_DELAY];
	assign green_group_delay        = common_config_zero[`LCFG_F_GREEN_DELAY];
	assign blue_group_delay         = common_config_zero[`LCFG_F_BLUE_DELAY];
	assign short_caterpillar_removal_enable = common_config_zero[`LCFG_F_SHORT_REMOVAL];
endmodule : lcfg_device

// ### rtl/lcfg_host.sv
// host end: makes the serial clock and shifts 64-bit command frames
`include "lcfg_map.svh"
module lcfg_host (
	input  wire logic               clk,        // system clock
	input  wire logic               rst,        // async reset, high
	lcfg_link_if.host               link,       // serial link
	input  wire logic               req_valid,  // request present
	input  lcfg_pkg::lcfg_cmd_id_t  req_id,     // command identifier
	input  lcfg_pkg::lcfg_word_t    req_data,   // write data, shifted out for reads too
	output logic                    req_ready,  // idle, request taken
	output logic                    rsp_valid,  // one-cycle readback strobe
	output lcfg_pkg::lcfg_word_t    rsp_data    // readback word
);
	logic [2:0]                 div_cnt;
	logic                       sclk_q;
	logic                       toggle;
	logic                       rise_ev;
	logic                       fall_ev;
	logic [1:0]                 sout_sync;
	lcfg_pkg::lcfg_host_state_t state;
	lcfg_pkg::lcfg_frame_t      tx_shift;
	lcfg_pkg::lcfg_word_t       rx_shift;
	lcfg_pkg::lcfg_bit_cnt_t    bit_cnt;
	logic                       is_read;
	logic                       frame_q;
	logic                       sin_q;

	// free-running serial clock from a divider, 12 system clocks per period
	assign toggle  = (div_cnt == `LCFG_SCLK_HALF_LAST);
	assign rise_ev = toggle & ~sclk_q;
	assign fall_ev = toggle & sclk_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= `LCFG_DIV_ZERO;
			sclk_q  <= 1'b0;
		end else if (toggle) begin
			div_cnt <= `LCFG_DIV_ZERO;
			sclk_q  <= ~sclk_q;
		end else begin
			div_cnt <= div_cnt + `LCFG_DIV_ONE;
		end
	end

	// returning data crosses into clk before it is sampled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sout_sync <= 2'h0;
		end else begin
			sout_sync <= {sout_sync[0], link.sout};
		end
	end

	// frame sequencer: bits leave on falling edges, readback is taken on rising ones
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= lcfg_pkg::LCFG_HOST_IDLE;
			req_ready <= 1'b1;
			tx_shift  <= 64'h0000_0000_0000_0000;
			rx_shift  <= 48'h0000_0000_0000;
			bit_cnt   <= `LCFG_BIT_ZERO;
			is_read   <= 1'b0;
			frame_q   <= 1'b0;
			sin_q     <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= 48'h0000_0000_0000;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state)
				lcfg_pkg::LCFG_HOST_IDLE: begin
					if (req_valid) begin
						tx_shift  <= {req_id, req_data};
						is_read   <= lcfg_pkg::lcfg_is_read_id(req_id);
						bit_cnt   <= `LCFG_BIT_ZERO;
						req_ready <= 1'b0;
						state     <= lcfg_pkg::LCFG_HOST_ARMED;
					end
				end
				lcfg_pkg::LCFG_HOST_ARMED: begin
					if (fall_ev) begin
						frame_q  <= 1'b1;
						sin_q    <= tx_shift[63];
						tx_shift <= {tx_shift[62:0], 1'b0};
						state    <= lcfg_pkg::LCFG_HOST_SHIFT;
					end
				end
				lcfg_pkg::LCFG_HOST_SHIFT: begin
					if (rise_ev) begin
						// device answers from bit 16 onward, most significant first
						if (bit_cnt > `LCFG_BIT_LAST_ID) begin
							rx_shift <= {rx_shift[46:0], sout_sync[1]};
						end
						bit_cnt <= bit_cnt + `LCFG_BIT_ONE;
					end else if (fall_ev) begin
						if (bit_cnt == `LCFG_BIT_DONE) begin
							frame_q   <= 1'b0;
							sin_q     <= 1'b0;
							rsp_valid <= is_read;
							rsp_data  <= rx_shift;
							req_ready <= 1'b1;
							state     <= lcfg_pkg::LCFG_HOST_IDLE;
						end else begin
							sin_q    <= tx_shift[63];
							tx_shift <= {tx_shift[62:0], 1'b0};
						end
					end
				end
			endcase
		end
	end

	assign link.sclk  = sclk_q;
	assign link.sin   = sin_q;
	assign link.frame = frame_q;
endmodule : lcfg_host

// ### tb/lcfg_assertions.sv
// wire-level checks on the serial config link between host and device
module lcfg_assertions (
	input wire logic clk,   // system clock
	input wire logic rst,   // async reset, high
	input wire logic sclk,  // serial clock
	input wire logic sin,   // host to device data
	input wire logic frame, // frame marker
	input wire logic sout   // device to host data, readback only
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sclk_q; // serial clock one cycle ago
	logic [6:0] rises;  // serial clock rises inside the current frame

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// delayed copy of the serial clock for edge finding
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sclk_q <= 1'b0;
		else
			sclk_q <= sclk;
	end

	// cleared between frames so that each frame is counted on its own
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rises <= 7'h00;
		else if (!frame)
			rises <= 7'h00;
		else if (sclk && !sclk_q)
			rises <= rises + 7'h01;
	end

	a_sin_on_fall: assert property ($changed(sin) |-> $fell(sclk))
		else $error("data line moved away from a clock fall");
	a_frame_on_fall: assert property ($changed(frame) |-> $fell(sclk))
		else $error("frame line moved away from a clock fall");
	a_frame_bits: assert property ($fell(frame) |-> rises == 7'h40)
		else $error("frame did not hold exactly 64 bits");
	a_bits_bound: assert property (frame |-> rises <= 7'h40)
		else $error("frame ran past 64 bits");
	a_frame_gap: assert property ($fell(frame) |-> !frame [*8])
		else $error("frames too close together");
	a_sin_idle: assert property (!frame |-> !sin)
		else $error("data line high outside a frame");
	a_id_msb_first: assert property ($rose(frame) |-> sin ##12 !sin)
		else $error("identifier not sent high bit first");
	a_sclk_high: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
		else $error("serial clock high phase not six cycles");
	a_sclk_low: assert property ($fell(sclk) |-> !sclk [*6] ##1 sclk)
		else $error("serial clock low phase not six cycles");
	// readback is shifted out fully by the last bit, so the line rests low between frames
	a_sout_idle: assert property (!frame |-> !sout)
		else $error("readback line high outside a frame");
	// the device moves its readback three clocks after the serial clock rises on the wire
	a_sout_on_rise: assert property ($changed(sout) |-> $past(sclk, 3) && !$past(sclk, 4))
		else $error("readback line moved away from a clock rise");
endmodule : lcfg_assertions

// ### tb/tb_led_matrix_config_register_map.sv
// self-checking bench: host and device joined by the link, driven from the host user side
module tb_led_matrix_config_register_map;
	timeunit 1ns;
	timeprecision 1ps;
	localparam lcfg_pkg::lcfg_word_t CFG_RST = 48'h2000_E000_0107;
	localparam lcfg_pkg::lcfg_word_t CFG_ONES = 48'hBFF1_F1DF_F11F;
	logic                   clk, rst, req_valid, req_ready, rsp_valid;
	logic                   stby, ps_p, vs_p, sr_p, gs_p;
	lcfg_pkg::lcfg_cmd_id_t req_id;
	lcfg_pkg::lcfg_word_t   req_data, rsp_data, rd, cfg, gs_data;
	logic [4:0]             oloc, sloc, cidx;
	logic [31:0]            olw, slw;
	logic [47:0]            ocw, scw;
	logic [63:0]            cap;
	logic [7:0]             ps_n, vs_n, sr_n, gs_n;
	int                     err_count, check_count;

	lcfg_link_if link ();
	lcfg_host lcfg_host_i (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
		.req_id(req_id), .req_data(req_data), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	lcfg_device lcfg_device_i (.clk(clk), .rst(rst), .link(link),
		.open_line_warnings(olw), .short_line_warnings(slw),
		.open_channel_warnings(ocw), .short_channel_warnings(scw),
		.common_config_zero(cfg), .device_count(), .predischarge_enable(),
		.power_save_enable(), .power_save_plus_level(), .open_led_removal_enable(),
		.scan_line_count(), .subperiod_count(), .multiplier_range_select(),
		.multiplier_factor(), .red_group_delay(), .green_group_delay(),
		.blue_group_delay(), .short_caterpillar_removal_enable(),
		.open_line_locate(oloc), .short_line_locate(sloc), .chip_index(cidx),
		.standby(stby), .power_save_pulse(ps_p), .vsync_pulse(vs_p),
		.soft_reset_pulse(sr_p), .gs_write_pulse(gs_p), .gs_write_data(gs_data));
	lcfg_assertions lcfg_assertions_i (.clk(clk), .rst(rst), .sclk(link.sclk),
		.sin(link.sin), .frame(link.frame), .sout(link.sout));

	always #2 clk = ~clk;

	// count action pulses; a pulse that lasts two cycles shows up as a double count
	always @(posedge clk) begin
		if (ps_p === 1'b1) ps_n <= ps_n + 8'h01;
		if (vs_p === 1'b1) vs_n <= vs_n + 8'h01;
		if (sr_p === 1'b1) sr_n <= sr_n + 8'h01;
		if (gs_p === 1'b1) gs_n <= gs_n + 8'h01;
	end

	// what the device really sees on the wire, bit by bit
	always @(posedge link.sclk) begin
		if (link.frame === 1'b1) cap <= {cap[62:0], link.sin};
	end

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one whole frame; reads send zero data so the wire image is known either way
	task automatic xfer(input lcfg_pkg::lcfg_cmd_id_t id, input lcfg_pkg::lcfg_word_t data);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_id <= id;
		req_data <= data;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		rd = 48'hFFFF_FFFF_FFFF;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (rsp_valid === 1'b1) rd = rsp_data;
		end while (req_ready !== 1'b1 && n < 3000);
		chk("req_ready", 1, req_ready);
		chk("link_frame", {id, data}, cap);
	endtask : xfer

	task automatic rdchk(input string name, input lcfg_pkg::lcfg_cmd_id_t id,
		input lcfg_pkg::lcfg_word_t exp);
		xfer(id, 48'h0000_0000_0000);
		chk(name, exp, rd);
	endtask : rdchk

	// whole word and every field port against slices of the expected word
	task automatic cfgchk(input lcfg_pkg::lcfg_word_t e);
		chk("config", e, cfg);
		chk("fields", {e[47], e[44:36], e[32:28], e[24:22], e[20:12], e[8], e[4:0]},
			{lcfg_device_i.short_caterpillar_removal_enable, lcfg_device_i.blue_group_delay,
			lcfg_device_i.green_group_delay, lcfg_device_i.red_group_delay,
			lcfg_device_i.multiplier_factor, lcfg_device_i.multiplier_range_select,
			lcfg_device_i.subperiod_count, lcfg_device_i.scan_line_count,
			lcfg_device_i.open_led_removal_enable, lcfg_device_i.power_save_plus_level,
			lcfg_device_i.power_save_enable, lcfg_device_i.predischarge_enable,
			lcfg_device_i.device_count});
	endtask : cfgchk

	task automatic finish_test();
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// a full run is 22 frames of some 800 cycles each
	initial begin
		#300000;
		err_count++;
		finish_test();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_id = 16'h0000;
		req_data = 48'h0000_0000_0000;
		olw = 32'h8000_0001;
		slw = 32'h1234_5678;
		ocw = 48'hA5A5_0000_FFFF;
		scw = 48'h0001_8000_0003;
		cap = 64'h0000_0000_0000_0000;
		{ps_n, vs_n, sr_n, gs_n} = 32'h0000_0000;
		err_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		cfgchk(CFG_RST);
		rdchk("read_cfg", 16'hAA60, CFG_RST);
		xfer(16'hAA00, 48'hFFFF_FFFF_FFFF);
		cfgchk(CFG_ONES);
		rdchk("read_cfg", 16'hAA60, CFG_ONES);
		xfer(16'hAA5F, 48'h0000_0000_0000);
		cfgchk(CFG_ONES);
		xfer(16'hAA0E, 48'hFFFF_FFFF_FFF5);
		xfer(16'hAA0F, 48'h0000_0000_000A);
		chk("locates", {oloc, sloc}, {5'h15, 5'h0A});
		rdchk("open_loc", 16'hAA6E, 48'h0000_0000_0015);
		rdchk("short_loc", 16'hAA6F, 48'h0000_0000_000A);
		xfer(16'hAA10, 48'h0000_0000_0013);
		chk("chip_index", 5'h13, cidx);
		rdchk("chip_index_rd", 16'hAA70, 48'h0000_0000_0013);
		rdchk("open_lines", 16'hAAA1, {16'h0000, olw});
		rdchk("short_lines", 16'hAAA3, {16'h0000, slw});
		rdchk("open_chans", 16'hAAA4, ocw);
		rdchk("short_chans", 16'hAAA5, scw);
		xfer(16'hAA00, 48'h0000_0000_0000);
		cfgchk(48'h2000_0000_0000);
		xfer(16'hAAB1, 48'h0000_0000_0000);
		chk("standby", 1, stby);
		xfer(16'hAA90, 48'h0000_0000_0000);
		xfer(16'hAA30, 48'h1234_5678_9ABC);
		xfer(16'hAAF0, 48'h0000_0000_0000);
		chk("gs_data", 48'h1234_5678_9ABC, gs_data);
		chk("pulses", {ps_n, vs_n, gs_n, sr_n}, 32'h0101_0100);
		xfer(16'hAA80, 48'h0000_0000_0000);
		cfgchk(CFG_RST);
		chk("reset_state", {oloc, sloc, cidx, stby}, 16'h0000);
		chk("gs_kept", 48'h1234_5678_9ABC, gs_data);
		chk("pulses", {ps_n, vs_n, gs_n, sr_n}, 32'h0101_0101);
		xfer(16'hAAB1, 48'h0000_0000_0000);
		chk("standby", 1, stby);
		xfer(16'hAAB0, 48'h0000_0000_0000);
		chk("standby", 0, stby);
		finish_test();
	end
endmodule : tb_led_matrix_config_register_map
